// ==== dv/tb_ccr_control_regs.sv ====
`timescale 1ns/1ps
module tb_ccr_control_regs;
	logic                 clock = 1'b0;
	logic                 reset_n = 1'b0;
	logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]           paddr = 8'h00;
	logic [31:0]          pwdata = 32'h0, prdata, rd;
	logic                 pready, pslverr, err;
	logic                 cmd_valid = 1'b0, cmd_ready;
	ccr_pkg::ccr_cmd_s    cmd = '0;
	logic [15:0]          reg_pair = 16'h0, probe_addr = 16'h0, fetch_addr;
	logic                 mem_req, mem_ack = 1'b0, fetch_blocked;
	ccr_pkg::ccr_mem_s    mem;
	logic [7:0]           mem_rdata = 8'h00, flags, alu_result, wdat = 8'h00;
	logic [15:0]          waddr = 16'h0;
	logic                 irq_req = 1'b0, irq_masked = 1'b0, irq_low = 1'b0;
	logic                 irq_take;
	ccr_pkg::ccr_region_e probe_region;
	logic [1:0]           bank;
	int                   miscompares = 0, n_tests = 0, cyc = 0;
	logic [15:0] pa [11] = '{16'h0800, 16'h0fff, 16'h07ff, 16'h1000,
		16'hfbff, 16'hfc00, 16'hfedf, 16'hfee0, 16'hfeff, 16'hff00, 16'hffff};
	ccr_pkg::ccr_region_e pr [11] = '{ccr_pkg::RG_PAGE_CALL,
		ccr_pkg::RG_PAGE_CALL, ccr_pkg::RG_OTHER, ccr_pkg::RG_OTHER,
		ccr_pkg::RG_OTHER, ccr_pkg::RG_RAM, ccr_pkg::RG_RAM, ccr_pkg::RG_BANK,
		ccr_pkg::RG_BANK, ccr_pkg::RG_SFR, ccr_pkg::RG_SFR};

	ccr_control_regs #(.RAM_BYTES(768)) i_ccr_control_regs (
		.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .cmd_valid(cmd_valid),
		.cmd(cmd), .reg_pair(reg_pair), .cmd_ready(cmd_ready),
		.mem_req(mem_req), .mem(mem), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .irq_req(irq_req), .irq_masked(irq_masked),
		.irq_low(irq_low), .irq_take(irq_take), .probe_addr(probe_addr),
		.probe_region(probe_region), .fetch_addr(fetch_addr),
		.fetch_blocked(fetch_blocked), .flags(flags),
		.alu_result(alu_result), .bank(bank));

	always #25 clock = ~clock;

	// Memory: odd bytes read 12, even 34; one ack per byte
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mem_ack <= 1'b0;
		end else begin
			mem_ack <= mem_req && !mem_ack;
			mem_rdata <= mem.addr[0] ? 8'h12 : 8'h34;
			if (mem_req && mem_ack && mem.wr) begin
				waddr <= mem.addr;
				wdat <= mem.wdata;
			end
		end
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_ready;
		do begin
			@(posedge clock);
		end while (cmd_ready !== 1'b1);
	endtask

	task op(input ccr_pkg::ccr_op_e o, input logic [15:0] v,
		input ccr_pkg::ccr_alu_s al = '0, input logic [2:0] ln = 3'h1,
		input logic ur = 1'b0);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd <= '{o, ln, ur, v, al};
		do begin
			@(posedge clock);
		end while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		wait_ready;
	endtask

	task sp_is(input logic [15:0] e);
		apb(1'b0, ccr_pkg::OFS_SP, 32'h0);
		chk("sp", rd, {16'h0, e});
	endtask

	task alu(input logic [15:0] ab, input logic s, input logic [7:0] r,
		input logic [2:0] zhc);
		op(ccr_pkg::OP_ALU, ab, {1'b1, s, 5'b01110});
		chk("alu", alu_result, r);
		chk("zhc", {flags[6], flags[4], flags[0]}, zhc);
	endtask

	task irq_is(input logic e);
		@(posedge clock);
		chk("take", irq_take, e);
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		wait_ready;
		chk("pc", fetch_addr, 16'h1234);
		chk("flags", flags, 8'h02);
		apb(1'b0, ccr_pkg::OFS_FLAGS, 32'h0);
		chk("flags_rd", rd, 32'h2);
		apb(1'b1, ccr_pkg::OFS_SP, 32'h0000fee0);
		sp_is(16'hfee0);
		apb(1'b0, ccr_pkg::OFS_STAT, 32'h0);
		chk("sp_set", rd[2], 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped_err", err, 1'b1);
		chk("unmapped_rd", rd, 32'h0);
		apb(1'b1, ccr_pkg::OFS_PC, 32'h1);
		chk("pc_wr", err, 1'b1);
		$display("test reset_apb done");
		op(ccr_pkg::OP_SEQ, 16'h0, '0, 3'h3);
		chk("pc", fetch_addr, 16'h1237);
		op(ccr_pkg::OP_BRANCH, 16'h4000);
		chk("pc", fetch_addr, 16'h4000);
		op(ccr_pkg::OP_CALL_PAGE, 16'hf123);
		chk("pc", fetch_addr, 16'h0923);
		sp_is(16'hfede);
		chk("waddr", waddr, 16'hfede);
		reg_pair <= 16'hfee4;
		op(ccr_pkg::OP_BRANCH, 16'h0, '0, 3'h1, 1'b1);
		chk("pc", fetch_addr, 16'hfee4);
		chk("blocked", fetch_blocked, 1'b1);
		op(ccr_pkg::OP_BRANCH, 16'h0100);
		chk("blocked", fetch_blocked, 1'b0);
		$display("test counter done");
		apb(1'b1, ccr_pkg::OFS_FLAGS, 32'h80);
		irq_req <= 1'b1;
		irq_low <= 1'b1;
		irq_is(1'b0);
		irq_low <= 1'b0;
		irq_is(1'b1);
		irq_masked <= 1'b1;
		irq_is(1'b0);
		irq_masked <= 1'b0;
		op(ccr_pkg::OP_MASK_ALL, 16'h0);
		chk("ie", flags[7], 1'b0);
		irq_is(1'b0);
		op(ccr_pkg::OP_UNMASK, 16'h0);
		chk("ie", flags[7], 1'b1);
		for (int i = 0; i < 4; i++) begin
			op(ccr_pkg::OP_BANK, 16'(i));
			chk("bank", bank, 32'(i));
		end
		op(ccr_pkg::OP_MASK_ALL, 16'h0);
		op(ccr_pkg::OP_PUSH_FLAGS, 16'h0);
		chk("push", {waddr, wdat}, 24'hfedd28);
		op(ccr_pkg::OP_POP_FLAGS, 16'h0);
		chk("pop", flags, 8'h12);
		sp_is(16'hfede);
		op(ccr_pkg::OP_UNMASK, 16'h0);
		op(ccr_pkg::OP_INT_ENTRY, 16'h0);
		chk("ie", flags[7], 1'b0);
		chk("waddr", waddr, 16'hfedb);
		sp_is(16'hfedb);
		op(ccr_pkg::OP_INT_RET, 16'h0);
		chk("pc", fetch_addr, 16'h3412);
		chk("flags", flags, 8'h12);
		sp_is(16'hfede);
		op(ccr_pkg::OP_RET, 16'h0);
		chk("pc", fetch_addr, 16'h1234);
		sp_is(16'hfee0);
		op(ccr_pkg::OP_BREAK, 16'h003e);
		chk("brk", {waddr, wdat}, 24'hfedd34);
		op(ccr_pkg::OP_BREAK_RET, 16'h0);
		chk("pc", fetch_addr, 16'h3412);
		sp_is(16'hfee0);
		$display("test flags_stack done");
		alu(16'h0f01, 1'b0, 8'h10, 3'b010);
		alu(16'hff01, 1'b0, 8'h00, 3'b111);
		alu(16'h1001, 1'b1, 8'h0f, 3'b010);
		alu(16'h0001, 1'b1, 8'hff, 3'b011);
		$display("test alu done");
		for (int i = 0; i < 11; i++) begin
			@(posedge clock);
			probe_addr <= pa[i];
			repeat (2) @(posedge clock);
			chk("region", 32'(probe_region), 32'(pr[i]));
		end
		$display("test decode done");
		op(ccr_pkg::OP_LOAD_SP, 16'hfe00);
		sp_is(16'hfe00);
		apb(1'b1, ccr_pkg::OFS_SP, 32'h00001000);
		op(ccr_pkg::OP_PUSH_FLAGS, 16'h0);
		chk("waddr", waddr, 16'hfedd);
		apb(1'b0, ccr_pkg::OFS_STAT, 32'h0);
		chk("fault", rd[0], 1'b1);
		chk("fetch_flt", rd[1], 1'b1);
		apb(1'b1, ccr_pkg::OFS_STAT, 32'h1);
		apb(1'b0, ccr_pkg::OFS_STAT, 32'h0);
		chk("fault_clr", rd[0], 1'b0);
		$display("test stack_fault done");
		tally_and_finish;
	end
endmodule

// ==== shared/ccr_pkg.sv ====
package ccr_pkg;
	// Memory map
	localparam logic [15:0] PAGE_CALL_LO = 16'h0800;
	localparam logic [15:0] PAGE_CALL_HI = 16'h0fff;
	localparam logic [15:0] RAM_LO_384   = 16'hfd80;
	localparam logic [15:0] RAM_LO_512   = 16'hfd00;
	localparam logic [15:0] RAM_LO_768   = 16'hfc00;
	localparam logic [15:0] RAM_HI       = 16'hfeff;
	localparam logic [15:0] BANK_LO      = 16'hfee0;
	localparam logic [15:0] SFR_LO       = 16'hff00;
	localparam logic [15:0] RST_VEC_LO   = 16'h0000;
	localparam logic [15:0] RST_VEC_HI   = 16'h0001;
	localparam int          PAGE_OFS_W   = 11;

	// Flags word layout
	localparam logic [7:0] FLAGS_RST   = 8'h02;
	localparam logic [7:0] FLAGS_WMASK = 8'hfb;
	localparam int IE_BIT    = 7;
	localparam int ZERO_BIT  = 6;
	localparam int BANKH_BIT = 5;
	localparam int HC_BIT    = 4;
	localparam int BANKL_BIT = 3;
	localparam int ISL_BIT   = 1;
	localparam int CY_BIT    = 0;

	// APB register offsets
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_SP    = 8'h04;
	localparam logic [7:0] OFS_PC    = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [15:0] SP_RST   = 16'h0000;

	typedef enum logic [3:0] {
		OP_NOP, OP_SEQ, OP_BRANCH, OP_CALL_PAGE, OP_PUSH_FLAGS,
		OP_POP_FLAGS, OP_INT_ENTRY, OP_BREAK, OP_INT_RET, OP_BREAK_RET,
		OP_RET, OP_MASK_ALL, OP_UNMASK, OP_BANK, OP_ALU, OP_LOAD_SP
	} ccr_op_e;

	typedef enum logic [2:0] {
		RG_PAGE_CALL, RG_RAM, RG_BANK, RG_SFR, RG_OTHER
	} ccr_region_e;

	typedef enum logic [2:0] {
		ST_VEC_LO, ST_VEC_HI, ST_IDLE, ST_PUSH, ST_POP
	} ccr_state_e;

	typedef struct packed {
		logic arith;
		logic sub;
		logic with_cy;
		logic z_en;
		logic hc_en;
		logic cy_en;
		logic cy_val;
	} ccr_alu_s;

	typedef struct packed {
		ccr_op_e     op;
		logic [2:0]  len;
		logic        use_reg;
		logic [15:0] value;
		ccr_alu_s    alu;
	} ccr_cmd_s;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ccr_mem_s;
endpackage

// ==== src/ccr_control_regs.sv ====
`timescale 1ns/1ps
// What this block does
// - Page call target forced into 0800H..0FFFH
// - RAM start follows size variant, ends FEFFH
// - FEE0H..FEFFH decoded as four register banks
// - No instruction fetch from bank window
// - FF00H..FFFFH decoded as peripheral space
// - Program counter advances by instruction length
// - Branch loads immediate or register pair
// - Reset loads counter from 0000H/0001H
// - Vector low byte even, high odd
// - Flags pushed and popped on stack
// - Flags word resets to 02H
// - Interrupts blocked while enable flag clear
// - Enable cleared by mask/acknowledge, set unmask
// - Zero flag tracks zero result
// - Two-bit bank field set by switch
// - Half carry from bit 3 carry/borrow
// - Low priority refused while service flag clear
// - Carry: arithmetic, rotate, bit accumulator
// - Stack pointer predecrement, postincrement
// - Stack confined to internal RAM
// - Stack pointer must be loaded before use
module ccr_control_regs #(
	parameter int RAM_BYTES = 768
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// Core command port
	input  wire logic                 cmd_valid,
	input  wire ccr_pkg::ccr_cmd_s    cmd,
	input  wire logic [15:0]          reg_pair,
	output logic                      cmd_ready,
	// Stack and vector memory port
	output logic                      mem_req,
	output ccr_pkg::ccr_mem_s         mem,
	input  wire logic                 mem_ack,
	input  wire logic [7:0]           mem_rdata,
	// Interrupt gating
	input  wire logic                 irq_req,
	input  wire logic                 irq_masked,
	input  wire logic                 irq_low,
	output logic                      irq_take,
	// Address decode and state view
	input  wire logic [15:0]          probe_addr,
	output ccr_pkg::ccr_region_e      probe_region,
	output logic [15:0]               fetch_addr,
	output logic                      fetch_blocked,
	output logic [7:0]                flags,
	output logic [7:0]                alu_result,
	output logic [1:0]                bank
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	localparam logic [15:0] RAM_LO =
		(RAM_BYTES == 384) ? ccr_pkg::RAM_LO_384 :
		(RAM_BYTES == 512) ? ccr_pkg::RAM_LO_512 :
		ccr_pkg::RAM_LO_768;

	function automatic ccr_pkg::ccr_region_e region_of(
		input logic [15:0] a
	);
		if (a >= ccr_pkg::SFR_LO) begin
			region_of = ccr_pkg::RG_SFR;
		end else if (a >= ccr_pkg::BANK_LO && a <= ccr_pkg::RAM_HI) begin
			region_of = ccr_pkg::RG_BANK;
		end else if (a >= RAM_LO && a <= ccr_pkg::RAM_HI) begin
			region_of = ccr_pkg::RG_RAM;
		end else if (a >= ccr_pkg::PAGE_CALL_LO &&
			a <= ccr_pkg::PAGE_CALL_HI) begin
			region_of = ccr_pkg::RG_PAGE_CALL;
		end else begin
			region_of = ccr_pkg::RG_OTHER;
		end
	endfunction

	ccr_pkg::ccr_state_e state_reg;
	ccr_pkg::ccr_op_e    op_reg;
	ccr_pkg::ccr_mem_s   mem_reg;
	logic [15:0]         pc_reg;
	logic [15:0]         pc_next;
	logic [15:0]         sp_reg;
	logic [15:0]         vec_reg;
	logic [15:0]         tgt_reg;
	logic [7:0]          flags_reg;
	logic [7:0]          alu_res_reg;
	logic [31:0]         prdata_reg;
	logic [1:0]          idx_reg;
	logic [1:0]          last_reg;
	logic [1:0]          n_bytes;
	logic [1:0]          first_idx;
	logic                mem_req_reg;
	logic                sp_loaded_reg;
	logic                stack_fault_reg;
	logic                fetch_flt_reg;
	logic                fetch_blk_reg;
	logic                boot_done_reg;
	logic                is_push;
	logic                is_pop;
	logic                stack_ok;
	logic                cmd_go;
	logic                apb_wr;
	logic                apb_hit;
	logic                push_go;
	logic                pop_go;
	logic                step_ack;
	logic                step_last;
	logic [8:0]          alu_sum;
	logic [4:0]          alu_nib;
	logic                alu_cin;
	logic [7:0]          alu_a;
	logic [7:0]          alu_b;
	logic [1:0]          cmd_bank;
	logic [15:0]         cmd_value;

	assign cmd_ready = state_reg == ccr_pkg::ST_IDLE;
	assign cmd_go    = cmd_valid && cmd_ready;
	assign cmd_value = cmd.value;
	assign cmd_bank  = cmd.value[1:0];
	assign step_ack  = mem_req_reg && mem_ack;
	assign step_last = idx_reg == last_reg;

	// Stack sequence shape per command
	always_comb begin
		is_push   = 1'b0;
		is_pop    = 1'b0;
		n_bytes   = 2'd3;
		first_idx = 2'd0;
		case (cmd.op)
			ccr_pkg::OP_INT_ENTRY, ccr_pkg::OP_BREAK: begin
				is_push = 1'b1;
			end
			ccr_pkg::OP_CALL_PAGE: begin
				is_push   = 1'b1;
				n_bytes   = 2'd2;
				first_idx = 2'd1;
			end
			ccr_pkg::OP_PUSH_FLAGS: begin
				is_push = 1'b1;
				n_bytes = 2'd1;
			end
			ccr_pkg::OP_INT_RET, ccr_pkg::OP_BREAK_RET: begin
				is_pop = 1'b1;
			end
			ccr_pkg::OP_RET: begin
				is_pop  = 1'b1;
				n_bytes = 2'd2;
			end
			ccr_pkg::OP_POP_FLAGS: begin
				is_pop    = 1'b1;
				n_bytes   = 2'd1;
				first_idx = 2'd2;
			end
			default: begin
			end
		endcase
	end

	// Whole transfer must stay inside RAM
	always_comb begin
		if (is_push) begin
			stack_ok = {1'b0, sp_reg} >= {1'b0, RAM_LO} + 17'(n_bytes) &&
				{1'b0, sp_reg} <= {1'b0, ccr_pkg::RAM_HI} + 17'h1;
		end else begin
			stack_ok = sp_reg >= RAM_LO &&
				{1'b0, sp_reg} + 17'(n_bytes) <=
				{1'b0, ccr_pkg::RAM_HI} + 17'h1;
		end
		stack_ok = stack_ok && sp_loaded_reg;
	end

	assign push_go = cmd_go && is_push && stack_ok;
	assign pop_go  = cmd_go && is_pop && stack_ok;

	function automatic logic [7:0] push_byte(input logic [1:0] i);
		if (i == 2'd0) begin
			push_byte = flags_reg;
		end else if (i == 2'd1) begin
			push_byte = pc_reg[15:8];
		end else begin
			push_byte = pc_reg[7:0];
		end
	endfunction

	// Arithmetic flags
	assign alu_a   = cmd.value[15:8];
	assign alu_b   = cmd.value[7:0];
	assign alu_cin = cmd.alu.with_cy && flags_reg[ccr_pkg::CY_BIT];
	always_comb begin
		if (cmd.alu.sub) begin
			alu_sum = {1'b0, alu_a} - {1'b0, alu_b} - 9'(alu_cin);
			alu_nib = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]} -
				5'(alu_cin);
		end else begin
			alu_sum = {1'b0, alu_a} + {1'b0, alu_b} + 9'(alu_cin);
			alu_nib = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} +
				5'(alu_cin);
		end
	end

	// Sequencer
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg     <= ccr_pkg::ST_VEC_LO;
			op_reg        <= ccr_pkg::OP_NOP;
			idx_reg       <= 2'd0;
			last_reg      <= 2'd0;
			vec_reg       <= ccr_pkg::RST_VEC_LO;
			tgt_reg       <= ccr_pkg::PAGE_CALL_LO;
			boot_done_reg <= 1'b0;
		end else begin
			case (state_reg)
				ccr_pkg::ST_VEC_LO: begin
					if (step_ack) begin
						state_reg <= ccr_pkg::ST_VEC_HI;
					end
				end
				ccr_pkg::ST_VEC_HI: begin
					if (step_ack) begin
						state_reg     <= ccr_pkg::ST_IDLE;
						boot_done_reg <= 1'b1;
					end
				end
				ccr_pkg::ST_IDLE: begin
					if (push_go || pop_go) begin
						state_reg <= push_go ? ccr_pkg::ST_PUSH :
							ccr_pkg::ST_POP;
						op_reg    <= cmd.op;
						idx_reg   <= first_idx;
						// Last byte index of this sequence
						last_reg  <= first_idx + n_bytes - 2'd1;
						vec_reg   <= {cmd.value[15:1], 1'b0};
						tgt_reg   <= ccr_pkg::PAGE_CALL_LO |
							{5'h00, cmd.value[ccr_pkg::PAGE_OFS_W-1:0]};
					end
				end
				ccr_pkg::ST_PUSH: begin
					if (step_ack) begin
						idx_reg <= idx_reg + 2'd1;
						if (step_last) begin
							state_reg <= (op_reg == ccr_pkg::OP_CALL_PAGE ||
								op_reg == ccr_pkg::OP_PUSH_FLAGS) ?
								ccr_pkg::ST_IDLE : ccr_pkg::ST_VEC_LO;
						end
					end
				end
				ccr_pkg::ST_POP: begin
					if (step_ack) begin
						idx_reg <= idx_reg + 2'd1;
						if (step_last) begin
							state_reg <= ccr_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state_reg <= ccr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Memory request
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mem_req_reg   <= 1'b1;
			mem_reg.wr    <= 1'b0;
			mem_reg.addr  <= ccr_pkg::RST_VEC_LO;
			mem_reg.wdata <= 8'h00;
		end else if (push_go) begin
			mem_req_reg   <= 1'b1;
			mem_reg.wr    <= 1'b1;
			mem_reg.addr  <= sp_reg - 16'h1;
			mem_reg.wdata <= push_byte(first_idx);
		end else if (pop_go) begin
			mem_req_reg  <= 1'b1;
			mem_reg.wr   <= 1'b0;
			mem_reg.addr <= sp_reg;
		end else if (step_ack) begin
			mem_req_reg <= 1'b0;
			mem_reg.wr  <= 1'b0;
			if (state_reg == ccr_pkg::ST_VEC_LO) begin
				mem_req_reg  <= 1'b1;
				mem_reg.addr <= {vec_reg[15:1], 1'b1};
			end else if (state_reg == ccr_pkg::ST_PUSH) begin
				if (!step_last) begin
					mem_req_reg   <= 1'b1;
					mem_reg.wr    <= 1'b1;
					mem_reg.addr  <= sp_reg - 16'h1;
					mem_reg.wdata <= push_byte(idx_reg + 2'd1);
				end else if (op_reg == ccr_pkg::OP_INT_ENTRY ||
					op_reg == ccr_pkg::OP_BREAK) begin
					mem_req_reg  <= 1'b1;
					mem_reg.addr <= vec_reg;
				end
			end else if (state_reg == ccr_pkg::ST_POP && !step_last) begin
				mem_req_reg  <= 1'b1;
				mem_reg.addr <= sp_reg + 16'h1;
			end
		end
	end

	// Stack pointer
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sp_reg        <= ccr_pkg::SP_RST;
			sp_loaded_reg <= 1'b0;
		end else if (push_go || (step_ack && state_reg ==
			ccr_pkg::ST_PUSH && !step_last)) begin
			sp_reg <= sp_reg - 16'h1;
		end else if (step_ack && state_reg == ccr_pkg::ST_POP) begin
			sp_reg <= sp_reg + 16'h1;
		end else if (cmd_go && cmd.op == ccr_pkg::OP_LOAD_SP) begin
			sp_reg        <= cmd.value;
			sp_loaded_reg <= 1'b1;
		end else if (apb_wr && paddr == ccr_pkg::OFS_SP &&
			state_reg == ccr_pkg::ST_IDLE) begin
			sp_reg        <= pwdata[15:0];
			sp_loaded_reg <= 1'b1;
		end
	end

	// Program counter
	always_comb begin
		pc_next = pc_reg;
		if (cmd_go && cmd.op == ccr_pkg::OP_SEQ) begin
			pc_next = pc_reg + {13'h0000, cmd.len};
		end else if (cmd_go && cmd.op == ccr_pkg::OP_BRANCH) begin
			pc_next = cmd.use_reg ? reg_pair : cmd.value;
		end
		if (step_ack) begin
			if (state_reg == ccr_pkg::ST_VEC_LO) begin
				pc_next[7:0] = mem_rdata;
			end else if (state_reg == ccr_pkg::ST_VEC_HI) begin
				pc_next[15:8] = mem_rdata;
			end else if (state_reg == ccr_pkg::ST_POP) begin
				if (idx_reg == 2'd0) begin
					pc_next[7:0] = mem_rdata;
				end else if (idx_reg == 2'd1) begin
					pc_next[15:8] = mem_rdata;
				end
			end else if (state_reg == ccr_pkg::ST_PUSH && step_last &&
				op_reg == ccr_pkg::OP_CALL_PAGE) begin
				pc_next = tgt_reg;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pc_reg        <= ccr_pkg::RST_VEC_LO;
			fetch_blk_reg <= 1'b0;
		end else begin
			pc_reg        <= pc_next;
			fetch_blk_reg <= region_of(pc_next) == ccr_pkg::RG_BANK;
		end
	end

	// Flags word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			flags_reg   <= ccr_pkg::FLAGS_RST;
			alu_res_reg <= 8'h00;
		end else if (step_ack && state_reg == ccr_pkg::ST_POP &&
			idx_reg == 2'd2) begin
			flags_reg <= mem_rdata & ccr_pkg::FLAGS_WMASK;
		end else if (cmd_go) begin
			case (cmd.op)
				ccr_pkg::OP_MASK_ALL: flags_reg[ccr_pkg::IE_BIT] <= 1'b0;
				ccr_pkg::OP_UNMASK:   flags_reg[ccr_pkg::IE_BIT] <= 1'b1;
				ccr_pkg::OP_INT_ENTRY: begin
					if (stack_ok) begin
						flags_reg[ccr_pkg::IE_BIT] <= 1'b0;
					end
				end
				ccr_pkg::OP_BANK: begin
					flags_reg[ccr_pkg::BANKH_BIT] <= cmd.value[1];
					flags_reg[ccr_pkg::BANKL_BIT] <= cmd.value[0];
				end
				ccr_pkg::OP_ALU: begin
					alu_res_reg <= alu_sum[7:0];
					if (cmd.alu.z_en) begin
						flags_reg[ccr_pkg::ZERO_BIT] <=
							alu_sum[7:0] == 8'h00;
					end
					if (cmd.alu.hc_en) begin
						flags_reg[ccr_pkg::HC_BIT] <= alu_nib[4];
					end
					if (cmd.alu.cy_en) begin
						flags_reg[ccr_pkg::CY_BIT] <= cmd.alu.arith ?
							alu_sum[8] : cmd.alu.cy_val;
					end
				end
				default: begin
				end
			endcase
		end else if (apb_wr && paddr == ccr_pkg::OFS_FLAGS) begin
			flags_reg <= pwdata[7:0] & ccr_pkg::FLAGS_WMASK;
		end
	end

	assign irq_take = irq_req && !irq_masked &&
		flags_reg[ccr_pkg::IE_BIT] &&
		(flags_reg[ccr_pkg::ISL_BIT] || !irq_low);

	// Sticky status, set beats clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stack_fault_reg <= 1'b0;
			fetch_flt_reg   <= 1'b0;
		end else begin
			if (cmd_go && (is_push || is_pop) && !stack_ok) begin
				stack_fault_reg <= 1'b1;
			end else if (apb_wr && paddr == ccr_pkg::OFS_STAT &&
				pwdata[0]) begin
				stack_fault_reg <= 1'b0;
			end
			if (fetch_blk_reg) begin
				fetch_flt_reg <= 1'b1;
			end else if (apb_wr && paddr == ccr_pkg::OFS_STAT &&
				pwdata[1]) begin
				fetch_flt_reg <= 1'b0;
			end
		end
	end

	// APB slave, zero wait states
	assign pready  = 1'b1;
	assign apb_wr  = psel && penable && pwrite;
	assign apb_hit = paddr == ccr_pkg::OFS_FLAGS ||
		paddr == ccr_pkg::OFS_SP || paddr == ccr_pkg::OFS_PC ||
		paddr == ccr_pkg::OFS_STAT;
	assign pslverr = psel && penable && (!apb_hit ||
		(pwrite && paddr == ccr_pkg::OFS_PC));

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable) begin
			if (paddr == ccr_pkg::OFS_FLAGS) begin
				prdata_reg <= {24'h000000, flags_reg};
			end else if (paddr == ccr_pkg::OFS_SP) begin
				prdata_reg <= {16'h0000, sp_reg};
			end else if (paddr == ccr_pkg::OFS_PC) begin
				prdata_reg <= {16'h0000, pc_reg};
			end else if (paddr == ccr_pkg::OFS_STAT) begin
				prdata_reg <= {28'h0000000, !cmd_ready, sp_loaded_reg,
					fetch_flt_reg, stack_fault_reg};
			end else begin
				prdata_reg <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			probe_region <= ccr_pkg::RG_OTHER;
		end else begin
			probe_region <= region_of(probe_addr);
		end
	end

	assign prdata        = prdata_reg;
	assign mem_req       = mem_req_reg;
	assign mem           = mem_reg;
	assign fetch_addr    = pc_reg;
	assign fetch_blocked = fetch_blk_reg;
	assign flags         = flags_reg;
	assign alu_result    = alu_res_reg;
	assign bank          = {flags_reg[ccr_pkg::BANKH_BIT],
		flags_reg[ccr_pkg::BANKL_BIT]};

	a_boot_vector: assert property (
		state_reg == ccr_pkg::ST_VEC_LO && !boot_done_reg |->
		mem.addr == ccr_pkg::RST_VEC_LO && mem_req)
		else $error("reset vector not read from low vector byte");
	a_vector_pairing: assert property (
		state_reg == ccr_pkg::ST_VEC_HI && mem_ack |->
		mem.addr[0] ##1 fetch_addr[15:8] == $past(mem_rdata))
		else $error("vector high byte not from odd address");
	a_seq_advance: assert property (
		cmd_go && cmd.op == ccr_pkg::OP_SEQ |=>
		fetch_addr == $past(fetch_addr) + 16'($past(cmd.len)))
		else $error("counter did not advance by length");
	a_branch_load: assert property (
		cmd_go && cmd.op == ccr_pkg::OP_BRANCH && !cmd.use_reg |=>
		fetch_addr == $past(cmd_value))
		else $error("branch target not loaded");
	a_page_target: assert property (
		state_reg == ccr_pkg::ST_PUSH && mem_ack && step_last &&
		op_reg == ccr_pkg::OP_CALL_PAGE |=>
		region_of(fetch_addr) == ccr_pkg::RG_PAGE_CALL)
		else $error("page call left its entry area");
	a_fetch_window: assert property (
		fetch_blocked == (region_of(fetch_addr) == ccr_pkg::RG_BANK))
		else $error("bank window fetch not flagged");
	a_irq_gating: assert property (
		!flags[ccr_pkg::IE_BIT] || (irq_low &&
		!flags[ccr_pkg::ISL_BIT]) |-> !irq_take)
		else $error("interrupt taken while blocked");
	a_entry_masks: assert property (
		push_go && cmd.op == ccr_pkg::OP_INT_ENTRY |=>
		!flags[ccr_pkg::IE_BIT] && mem.wdata == $past(flags))
		else $error("entry did not mask or push old flags");
	a_zero_result: assert property (
		cmd_go && cmd.op == ccr_pkg::OP_ALU && cmd.alu.z_en |=>
		flags[ccr_pkg::ZERO_BIT] == (alu_result == 8'h00))
		else $error("zero flag wrong");
	a_bank_switch: assert property (
		cmd_go && cmd.op == ccr_pkg::OP_BANK |=> bank == $past(cmd_bank))
		else $error("bank field not switched");
	a_stack_pointer: assert property (
		mem_req && (state_reg == ccr_pkg::ST_PUSH ||
		state_reg == ccr_pkg::ST_POP) |-> mem.addr == sp_reg &&
		mem.addr >= RAM_LO && mem.addr <= ccr_pkg::RAM_HI)
		else $error("stack access off pointer or outside RAM");
	a_unloaded_sp: assert property (
		!sp_loaded_reg |-> state_reg != ccr_pkg::ST_PUSH &&
		state_reg != ccr_pkg::ST_POP)
		else $error("stack used before pointer load");

	c_int_entry: cover property (push_go &&
		cmd.op == ccr_pkg::OP_INT_ENTRY ##[1:40]
		state_reg == ccr_pkg::ST_IDLE);
	c_int_return: cover property (pop_go &&
		cmd.op == ccr_pkg::OP_INT_RET);
	c_page_call: cover property (push_go &&
		cmd.op == ccr_pkg::OP_CALL_PAGE);
	c_stack_fault: cover property ($rose(stack_fault_reg));
endmodule
